/* cm3_pkg.sv */
// Purpose: shared constants and types for the compare mode 3 channel
// Assumes: 16-bit timer, single clock domain
// Notes: none
`default_nettype none
package cm3_pkg;
   localparam int unsigned CM3_WIDTH = 16;
   localparam logic [15:0] CM3_TIMER_MAX = 16'hffff;
   localparam logic [15:0] CM3_TIMER_RESET = 16'h0000;
   localparam logic [15:0] CM3_RELOAD_RESET = 16'h0000;
   localparam logic [15:0] CM3_COMPARE_RESET = 16'h0000;
   localparam logic [1:0] CM3_MODE_RESET = 2'h0;
   localparam logic [1:0] CM3_MODE_THREE = 2'h3;
   localparam logic [1:0] CM3_DEFECT_WINDOW = 2'h2;

   typedef logic [15:0] cm3_word_t;

   typedef struct packed {
      logic timer_we;
      logic reload_we;
      logic compare_we;
      logic control_we;
      logic nop;
      cm3_word_t wdata;
   } cm3_cpu_s;

   typedef enum logic [1:0] {
      CM3_SEQ_IDLE,
      CM3_SEQ_RELOAD,
      CM3_SEQ_ARMED
   } cm3_seq_e;
endpackage : cm3_pkg
`default_nettype wire

/* cm3_timer.sv */
// Purpose: 16-bit up-counting timer with reload on overflow
// Assumes: synchronous active-high reset
// Notes: software write of the count takes priority over counting
`timescale 1ns/1ps
`default_nettype none
module cm3_timer
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic run,
   input wire logic count_we,
   input wire logic [15:0] count_wdata,
   input wire logic [15:0] reload_value,
   output logic [15:0] count,
   output logic step,
   output logic overflow
);
   logic [15:0] count_reg;

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         count_reg <= cm3_pkg::CM3_TIMER_RESET;
      end
      else if (count_we)
      begin
         count_reg <= count_wdata;
      end
      else if (run)
      begin
         if (count_reg == cm3_pkg::CM3_TIMER_MAX)
         begin
            count_reg <= reload_value;
         end
         else
         begin
            count_reg <= count_reg + 16'h0001;
         end
      end
   end

   assign count = count_reg;
   assign step = run && !count_we;
   assign overflow = step && (count_reg == cm3_pkg::CM3_TIMER_MAX);
endmodule : cm3_timer
`default_nettype wire

/* cm3_channel.sv */
// Purpose: one compare channel in compare mode 3 with its allocated timer
// Assumes: cpu writes arrive as one-cycle strobes; nop marks an idle instruction slot
// Notes: models the preload defect of timers 0, 1, 7 and 8 behind HAS_DEFECT
//
// How it works
// - in mode 3 the pin goes high when timer equals compare value
// - on overflow the timer reloads and the pin goes low
// - reload equal to compare at overflow leaves pin unchanged
// - reload and timer writes of the compare value, then control, back to back keep the output low
`timescale 1ns/1ps
`default_nettype none
module cm3_channel
#(
   parameter bit HAS_DEFECT = 1'b1
)
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire cm3_pkg::cm3_cpu_s cpu,
   input wire logic [1:0] channel_mode,
   output logic [15:0] timer_count,
   output logic compare_out,
   output logic output_blocked
);
   logic [15:0] timer_reload_value_reg;
   logic [15:0] channel_compare_value_reg;
   logic timer_run_reg;
   logic compare_out_reg;
   logic compare_out_next;
   logic blocked_reg;
   logic [15:0] count_reg;
   logic [15:0] count_now;
   logic step;
   logic overflow;
   logic match;
   logic mode3;
   logic load_match_reg;
   logic defect_hit;
   cm3_pkg::cm3_seq_e seq_reg;

   cm3_timer u_timer
   (
      .sys_clk(sys_clk),
      .reset(reset),
      .run(timer_run_reg),
      .count_we(cpu.timer_we),
      .count_wdata(cpu.wdata),
      .reload_value(timer_reload_value_reg),
      .count(count_now),
      .step(step),
      .overflow(overflow)
   );

   assign mode3 = (channel_mode == cm3_pkg::CM3_MODE_THREE);
   // match is checked on the value reached by an increment
   assign match = step && !overflow
      && ((count_now + 16'h0001) == channel_compare_value_reg);
   // control write straight after the armed sequence hits the defect
   assign defect_hit = HAS_DEFECT && cpu.control_we
      && (seq_reg == cm3_pkg::CM3_SEQ_ARMED);

   // a timer load with the compare value is a match seen one slot later
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         load_match_reg <= 1'b0;
      end
      else
      begin
         load_match_reg <= cpu.timer_we && (cpu.wdata == channel_compare_value_reg);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         timer_reload_value_reg <= cm3_pkg::CM3_RELOAD_RESET;
         channel_compare_value_reg <= cm3_pkg::CM3_COMPARE_RESET;
      end
      else
      begin
         if (cpu.reload_we)
         begin
            timer_reload_value_reg <= cpu.wdata;
         end
         if (cpu.compare_we)
         begin
            channel_compare_value_reg <= cpu.wdata;
         end
      end
   end

   // pair control write starts the timer
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         timer_run_reg <= 1'b0;
      end
      else if (cpu.control_we)
      begin
         timer_run_reg <= 1'b1;
      end
   end

   // defect detector: reload then timer write with compare value, then control at once
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         seq_reg <= cm3_pkg::CM3_SEQ_IDLE;
      end
      else
      begin
         case (seq_reg)
            cm3_pkg::CM3_SEQ_IDLE:
            begin
               if (cpu.reload_we && cpu.wdata == channel_compare_value_reg)
               begin
                  seq_reg <= cm3_pkg::CM3_SEQ_RELOAD;
               end
            end
            cm3_pkg::CM3_SEQ_RELOAD:
            begin
               // timer first or a different value does not arm the defect
               if (cpu.timer_we && cpu.wdata == channel_compare_value_reg)
               begin
                  seq_reg <= cm3_pkg::CM3_SEQ_ARMED;
               end
               else if (cpu.reload_we && cpu.wdata == channel_compare_value_reg)
               begin
                  seq_reg <= cm3_pkg::CM3_SEQ_RELOAD;
               end
               else
               begin
                  seq_reg <= cm3_pkg::CM3_SEQ_IDLE;
               end
            end
            cm3_pkg::CM3_SEQ_ARMED:
            begin
               // any slot other than the control write, such as a nop, disarms
               seq_reg <= cm3_pkg::CM3_SEQ_IDLE;
            end
            default:
            begin
               seq_reg <= cm3_pkg::CM3_SEQ_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         blocked_reg <= 1'b0;
      end
      else if (defect_hit)
      begin
         blocked_reg <= 1'b1;
      end
      else if (cpu.reload_we || cpu.timer_we || !mode3)
      begin
         blocked_reg <= 1'b0;
      end
   end

   always_comb
   begin
      compare_out_next = compare_out_reg;
      if (!mode3)
      begin
         compare_out_next = 1'b0;
      end
      else if (overflow)
      begin
         if (timer_reload_value_reg != channel_compare_value_reg)
         begin
            compare_out_next = 1'b0;
         end
         // equal values: overflow and match cancel, level held
      end
      else if ((match || load_match_reg) && !blocked_reg && !defect_hit)
      begin
         compare_out_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         compare_out_reg <= 1'b0;
         count_reg <= cm3_pkg::CM3_TIMER_RESET;
      end
      else
      begin
         compare_out_reg <= compare_out_next;
         count_reg <= count_now;
      end
   end

   assign compare_out = compare_out_reg;
   assign output_blocked = blocked_reg;
   assign timer_count = count_reg;

   a_match_sets_pin: assert property (@(posedge sys_clk) disable iff (reset)
      mode3 && match && !blocked_reg && !defect_hit && !overflow |=> compare_out_reg)
      else $error("pin not set on compare match");

   a_load_match_sets: assert property (@(posedge sys_clk) disable iff (reset)
      mode3 && load_match_reg && !blocked_reg && !defect_hit && !overflow |=> compare_out_reg)
      else $error("pin not set after timer load with compare value");

   a_overflow_clears_pin: assert property (@(posedge sys_clk) disable iff (reset)
      mode3 && overflow && timer_reload_value_reg != channel_compare_value_reg
      |=> !compare_out_reg && count_now == $past(timer_reload_value_reg))
      else $error("overflow did not reload and clear pin");

   a_equal_reload_holds: assert property (@(posedge sys_clk) disable iff (reset)
      mode3 && overflow && timer_reload_value_reg == channel_compare_value_reg
      |=> $stable(compare_out_reg))
      else $error("pin changed with equal reload and compare");

   a_defect_keeps_low: assert property (@(posedge sys_clk) disable iff (reset)
      blocked_reg && !compare_out_reg && mode3 && !cpu.reload_we && !cpu.timer_we
      |=> !compare_out_reg)
      else $error("blocked output went high");

   a_defect_blocks_load: assert property (@(posedge sys_clk) disable iff (reset)
      mode3 && defect_hit && !compare_out_reg |=> !compare_out_reg && blocked_reg)
      else $error("defect sequence did not keep pin low");

   a_timer_increments: assert property (@(posedge sys_clk) disable iff (reset)
      step && !overflow |=> count_now == $past(count_now) + 16'h0001)
      else $error("timer did not increment");

   a_wrap_overflow: assert property (@(posedge sys_clk) disable iff (reset)
      step && count_now == cm3_pkg::CM3_TIMER_MAX |-> overflow)
      else $error("wrap without overflow");

   a_nop_disarms: assert property (@(posedge sys_clk) disable iff (reset)
      seq_reg == cm3_pkg::CM3_SEQ_ARMED && !cpu.control_we ##1 cpu.control_we
      |=> $stable(blocked_reg) || !blocked_reg)
      else $error("defect armed after intervening slot");

   a_timer_first_safe: assert property (@(posedge sys_clk) disable iff (reset)
      seq_reg == cm3_pkg::CM3_SEQ_IDLE && cpu.timer_we |=> seq_reg != cm3_pkg::CM3_SEQ_ARMED)
      else $error("timer-first order armed defect");
endmodule : cm3_channel
`default_nettype wire

/* cm3_channel_top_note.sv */
`timescale 1ns/1ps

/* cm3_pin_load.sv */
// Purpose: load on the compare output pin, counts rising edges
// Assumes: pin sampled on sys_clk, cleared by reset
// Notes: passive; drives nothing back into the channel
`timescale 1ns/1ps
`default_nettype none
module cm3_pin_load
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic pin,
   output logic [15:0] rises
);
   logic pin_reg;
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pin_reg <= 1'b0;
         rises <= 16'h0000;
      end
      else
      begin
         pin_reg <= pin;
         if (pin && !pin_reg)
         begin
            rises <= rises + 16'h0001;
         end
      end
   end
endmodule : cm3_pin_load
`default_nettype wire

/* tb_top.sv */
// Purpose: self-checking bench for the compare mode 3 channel
// Assumes: inputs driven at falling edge, all waits bounded
// Notes: each scenario restarts the channel from reset
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [4:0] TW = 5'h10;
   localparam logic [4:0] RW = 5'h08;
   localparam logic [4:0] CW = 5'h04;
   localparam logic [4:0] KW = 5'h02;
   localparam logic [4:0] NP = 5'h01;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   cm3_pkg::cm3_cpu_s cpu = '0;
   logic [1:0] channel_mode = 2'h3;
   logic [15:0] timer_count;
   logic compare_out;
   logic output_blocked;
   logic [15:0] rises;
   int fails = 0;
   int n_checks = 0;
   always #5 sys_clk = ~sys_clk;
   cm3_channel #(.HAS_DEFECT(1'b1)) cm3_channel_inst (.sys_clk(sys_clk), .reset(reset),
      .cpu(cpu), .channel_mode(channel_mode), .timer_count(timer_count),
      .compare_out(compare_out), .output_blocked(output_blocked));
   cm3_pin_load cm3_pin_load_inst (.sys_clk(sys_clk), .reset(reset), .pin(compare_out),
      .rises(rises));
   task automatic complete_run;
      if (fails == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [4:0] k, input logic [15:0] d);
      @(negedge sys_clk);
      cpu = cm3_pkg::cm3_cpu_s'({k, d});
   endtask : wr
   task automatic idle;
      @(negedge sys_clk);
      cpu = '0;
   endtask : idle
   task automatic restart(input logic [1:0] mode);
      @(negedge sys_clk);
      reset = 1'b1;
      cpu = '0;
      channel_mode = mode;
      repeat (2) @(negedge sys_clk);
      reset = 1'b0;
      chk(timer_count, 16'h0000);
      chk({14'h0000, compare_out, output_blocked}, 16'h0000);
   endtask : restart
   task automatic wait_pin(input logic lvl, input int bound);
      int i;
      for (i = 0; i < bound && compare_out !== lvl; i++) @(negedge sys_clk);
      if (compare_out !== lvl)
      begin
         fails++;
         $display("BAD %0t pin wait ran out", $time);
         complete_run();
      end
   endtask : wait_pin
   task automatic hold_pin(input logic lvl, input int n);
      repeat (n)
      begin
         @(negedge sys_clk);
         chk({15'h0000, compare_out}, {15'h0000, lvl});
      end
   endtask : hold_pin
   task automatic blk(input logic lvl);
      repeat (2) @(negedge sys_clk);
      chk({15'h0000, output_blocked}, {15'h0000, lvl});
   endtask : blk
   task automatic s_match(input logic [1:0] mode);
      restart(mode);
      wr(CW, 16'h0010);
      wr(TW, 16'h000c);
      wr(KW, 16'h0000);
      idle();
      chk({15'h0000, compare_out}, 16'h0000);
      if (mode == 2'h3)
      begin
         wait_pin(1'b1, 8);
         @(negedge sys_clk);
         chk(rises, 16'h0001);
      end
      else
         hold_pin(1'b0, 12);
   endtask : s_match
   task automatic s_overflow;
      restart(2'h3);
      wr(RW, 16'h0002);
      wr(CW, 16'hfff4);
      wr(TW, 16'hfff0);
      wr(KW, 16'h0000);
      idle();
      wait_pin(1'b1, 8);
      wait_pin(1'b0, 16);
      @(negedge sys_clk);
      chk(timer_count, 16'h0002);
   endtask : s_overflow
   task automatic s_same;
      restart(2'h3);
      wr(CW, 16'hfff4);
      wr(RW, 16'hfff4);
      wr(TW, 16'hfff0);
      wr(KW, 16'h0000);
      idle();
      wait_pin(1'b1, 8);
      hold_pin(1'b1, 20);
   endtask : s_same
   task automatic s_defect;
      restart(2'h3);
      wr(CW, 16'hfff0);
      wr(RW, 16'hfff0);
      wr(TW, 16'hfff0);
      wr(KW, 16'h0000);
      idle();
      blk(1'b1);
      hold_pin(1'b0, 30);
   endtask : s_defect
   task automatic s_fixes;
      restart(2'h3);
      wr(CW, 16'hfff0);
      wr(TW, 16'hfff0);
      wr(RW, 16'hfff0);
      wr(KW, 16'h0000);
      idle();
      blk(1'b0);
      chk({15'h0000, compare_out}, 16'h0001);
      restart(2'h3);
      wr(CW, 16'hfff0);
      wr(RW, 16'hfff0);
      wr(TW, 16'hfff0);
      wr(NP, 16'h0000);
      wr(KW, 16'h0000);
      idle();
      blk(1'b0);
      chk({15'h0000, compare_out}, 16'h0001);
      restart(2'h3);
      wr(CW, 16'hfff0);
      wr(RW, 16'hfff0);
      wr(TW, 16'hffef);
      wr(KW, 16'h0000);
      idle();
      blk(1'b0);
      wait_pin(1'b1, 6);
   endtask : s_fixes
   initial
   begin
      repeat (12) @(posedge sys_clk);
      s_match(2'h3);
      s_match(2'h2);
      s_overflow();
      s_same();
      s_defect();
      s_fixes();
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
